/* File: lower_limit_pkg.sv */
// Constants shared by the lower-limit compare bank and its comparator
package lower_limit_pkg;

    // Register data and serial frame layout
    localparam int          DATA_W        = 24;
    localparam int          ADDR_W        = 7;
    localparam int          NUM_CH        = 6;
    localparam int          CMD_BITS      = 8;
    localparam int          FRAME_BITS    = CMD_BITS + DATA_W;
    localparam int          CNT_W         = 6;
    localparam int          CMD_RD_BIT    = 7;
    localparam int          LIMIT_MSB     = 23;
    localparam int          LIMIT_LSB     = 0;

    // Register offsets
    localparam logic [6:0]  LOWER_LIMIT_CH1_ADDR = 7'h21;
    localparam logic [6:0]  LOWER_LIMIT_CH2_ADDR = 7'h22;
    localparam logic [6:0]  LOWER_LIMIT_CH3_ADDR = 7'h23;
    localparam logic [6:0]  LOWER_LIMIT_CH4_ADDR = 7'h24;
    localparam logic [6:0]  LOWER_LIMIT_CH5_ADDR = 7'h25;
    localparam logic [6:0]  LOWER_LIMIT_CH6_ADDR = 7'h26;

    // Values after reset, and command and frame end bit counts
    localparam logic [23:0] LIMIT_RESET   = 24'h000000;
    localparam logic [23:0] READ_UNMAPPED = 24'h000000;
    localparam logic [2:0]  PIN_IDLE      = 3'h4;     // {cs_n, sclk, din}
    localparam logic [5:0]  BIT_CNT_RESET = 6'h00;
    localparam logic [5:0]  CMD_DONE_CNT  = 6'h08;
    localparam logic [5:0]  FRAME_END_CNT = 6'h20;

    // Coding selections
    localparam logic        POL_UNIPOLAR  = 1'b1;
    localparam logic        FMT_OFFSET    = 1'b1;

endpackage : lower_limit_pkg

/* File: limit_compare.sv */
// One channel comparator: result against lower limit in the selected coding
`timescale 1ns/1ns
module limit_compare
    import lower_limit_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [DATA_W-1:0] result,
    input  wire logic [DATA_W-1:0] limit,
    input  wire logic              polarity_select,
    input  wire logic              output_format,
    output logic                   below_limit_flag
);

    logic              signed_mode;
    logic [DATA_W-1:0] result_key;
    logic [DATA_W-1:0] limit_key;

    // coding sets ordering
    // Two's complement bipolar codes become ordered by flipping the sign bit
    assign signed_mode = (polarity_select != POL_UNIPOLAR) && (output_format != FMT_OFFSET);
    assign result_key  = {result[DATA_W-1] ^ signed_mode, result[DATA_W-2:0]};
    assign limit_key   = {limit[DATA_W-1] ^ signed_mode, limit[DATA_W-2:0]};

    always_ff @(posedge clk) begin
        if (rst) begin
            below_limit_flag <= 1'b0;
        end else begin
            below_limit_flag <= (result_key < limit_key);
        end
    end

endmodule : limit_compare

/* File: lower_limit_compare_bank.sv */
// Lower-limit registers for channels 1 to 6 behind a serial control port
`timescale 1ns/1ns

module lower_limit_compare_bank
    import lower_limit_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    input  wire logic              SPI_CS_N,
    input  wire logic              SPI_SCLK,
    input  wire logic              SPI_DIN,
    output logic                   SPI_DOUT,
    input  wire logic [DATA_W-1:0] RESULT_CH1,
    input  wire logic [DATA_W-1:0] RESULT_CH2,
    input  wire logic [DATA_W-1:0] RESULT_CH3,
    input  wire logic [DATA_W-1:0] RESULT_CH4,
    input  wire logic [DATA_W-1:0] RESULT_CH5,
    input  wire logic [DATA_W-1:0] RESULT_CH6,
    input  wire logic              POLARITY_SELECT,
    input  wire logic              OUTPUT_FORMAT,
    output logic                   BELOW_LIMIT_FLAG_CH1,
    output logic                   BELOW_LIMIT_FLAG_CH2,
    output logic                   BELOW_LIMIT_FLAG_CH3,
    output logic                   BELOW_LIMIT_FLAG_CH4,
    output logic                   BELOW_LIMIT_FLAG_CH5,
    output logic                   BELOW_LIMIT_FLAG_CH6
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA
    } frame_state_t;

    typedef logic [DATA_W-1:0] word_t;

    // Pin synchronisers and filtered levels, packed {cs_n, sclk, din}
    logic [2:0]        pin_s0_reg;
    logic [2:0]        pin_s1_reg;
    logic [2:0]        pin_s2_reg;
    logic [2:0]        pin_level_reg;
    logic [2:0]        pin_level_next;
    logic              cs_n_level;
    logic              sclk_level;
    logic              din_level;
    logic              sclk_prev_reg;
    logic              cs_n_prev_reg;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              frame_start;

    // Frame handling
    frame_state_t      state_reg;
    frame_state_t      state_next;
    logic [CNT_W-1:0]  bit_cnt_reg;
    logic [CNT_W-1:0]  bit_cnt_next;
    logic [CMD_BITS-1:0] cmd_reg;
    logic [CMD_BITS-1:0] cmd_next;
    word_t             wr_shift_reg;
    word_t             tx_shift_reg;
    logic              dout_reg;
    logic              cmd_done;
    logic              frame_done;
    logic              is_read;
    logic [ADDR_W-1:0] frame_addr;

    // Register bank
    word_t             limit_reg  [NUM_CH];
    word_t             result_arr [NUM_CH];
    logic [NUM_CH-1:0] addr_hit;
    logic [NUM_CH-1:0] flag_vec;
    word_t             read_word;

    // Three-stage capture; only stage 1 looks at stage 0
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pin_s0_reg <= PIN_IDLE;
            pin_s1_reg <= PIN_IDLE;
            pin_s2_reg <= PIN_IDLE;
        end else begin
            pin_s0_reg <= {SPI_CS_N, SPI_SCLK, SPI_DIN};
            pin_s1_reg <= pin_s0_reg;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // A pin level changes only when stages 1 and 2 agree
    assign pin_level_next = (pin_s1_reg & pin_s2_reg) | (pin_level_reg & (pin_s1_reg ^ pin_s2_reg));

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pin_level_reg <= PIN_IDLE;
            sclk_prev_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
        end else begin
            pin_level_reg <= pin_level_next;
            sclk_prev_reg <= pin_level_reg[1];
            cs_n_prev_reg <= pin_level_reg[2];
        end
    end

    // Edge events on the filtered levels
    assign cs_n_level  = pin_level_reg[2];
    assign sclk_level  = pin_level_reg[1];
    assign din_level   = pin_level_reg[0];
    assign sclk_rise   = !cs_n_level && sclk_level && !sclk_prev_reg;
    assign sclk_fall   = !cs_n_level && !sclk_level && sclk_prev_reg;
    assign frame_start = !cs_n_level && cs_n_prev_reg;

    // Command byte: read flag on top, address below
    assign cmd_next   = {cmd_reg[CMD_BITS-2:0], din_level};   // Command byte as it completes
    assign is_read    = cmd_reg[CMD_RD_BIT];
    assign frame_addr = cmd_reg[ADDR_W-1:0];
    assign cmd_done   = sclk_rise && (bit_cnt_reg == CMD_DONE_CNT - 6'h01);
    assign frame_done = sclk_rise && (bit_cnt_reg == FRAME_END_CNT - 6'h01);

    // Frame sequencing
    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        if (cs_n_level) begin
            state_next   = ST_IDLE;
            bit_cnt_next = BIT_CNT_RESET;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (frame_start) begin
                        state_next   = ST_CMD;
                        bit_cnt_next = BIT_CNT_RESET;
                    end
                end
                ST_CMD: begin
                    if (sclk_rise) begin
                        bit_cnt_next = bit_cnt_reg + 6'h01;
                    end
                    if (cmd_done) begin
                        state_next = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (sclk_rise) begin
                        bit_cnt_next = bit_cnt_reg + 6'h01;
                    end
                    if (frame_done) begin
                        state_next = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= BIT_CNT_RESET;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Command and write-data shifters, sampled on SCLK rise
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            cmd_reg      <= '0;
            wr_shift_reg <= LIMIT_RESET;
        end else if (sclk_rise && state_reg == ST_CMD) begin
            cmd_reg <= {cmd_reg[CMD_BITS-2:0], din_level};
        end else if (sclk_rise && state_reg == ST_DATA) begin
            wr_shift_reg <= {wr_shift_reg[DATA_W-2:0], din_level};
        end
    end

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_decode
            assign addr_hit[ch] = (frame_addr == LOWER_LIMIT_CH1_ADDR + 7'(ch));
        end
    endgenerate

    always_comb begin
        read_word = READ_UNMAPPED;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (cmd_next[ADDR_W-1:0] == LOWER_LIMIT_CH1_ADDR + 7'(ch)) begin
                read_word = limit_reg[ch];
            end
        end
    end

    // Read data is loaded after the command byte, shifted out on SCLK fall
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            tx_shift_reg <= READ_UNMAPPED;
            dout_reg     <= 1'b0;
        end else if (cs_n_level) begin
            tx_shift_reg <= READ_UNMAPPED;
            dout_reg     <= 1'b0;
        end else if (cmd_done) begin
            tx_shift_reg <= cmd_next[CMD_RD_BIT] ? read_word : READ_UNMAPPED;
        end else if (sclk_fall && state_reg == ST_DATA) begin
            dout_reg     <= tx_shift_reg[DATA_W-1];
            tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
        end
    end

    assign SPI_DOUT = dout_reg;

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_limit
            always_ff @(posedge MCLK) begin
                if (SYS_RST) begin
                    limit_reg[ch] <= LIMIT_RESET;
                end else if (frame_done && !is_read && addr_hit[ch]) begin
                    limit_reg[ch] <= {wr_shift_reg[DATA_W-2:0], din_level};
                end
            end
        end
    endgenerate

    // Gather channel results for the comparator loop
    assign result_arr[0] = RESULT_CH1;
    assign result_arr[1] = RESULT_CH2;
    assign result_arr[2] = RESULT_CH3;
    assign result_arr[3] = RESULT_CH4;
    assign result_arr[4] = RESULT_CH5;
    assign result_arr[5] = RESULT_CH6;

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_cmp
            limit_compare u_cmp (
                .clk              (MCLK),
                .rst              (SYS_RST),
                .result           (result_arr[ch]),
                .limit            (limit_reg[ch]),
                .polarity_select  (POLARITY_SELECT),
                .output_format    (OUTPUT_FORMAT),
                .below_limit_flag (flag_vec[ch])
            );
        end
    endgenerate

    // Flag outputs, one per channel
    assign BELOW_LIMIT_FLAG_CH1 = flag_vec[0];
    assign BELOW_LIMIT_FLAG_CH2 = flag_vec[1];
    assign BELOW_LIMIT_FLAG_CH3 = flag_vec[2];
    assign BELOW_LIMIT_FLAG_CH4 = flag_vec[3];
    assign BELOW_LIMIT_FLAG_CH5 = flag_vec[4];
    assign BELOW_LIMIT_FLAG_CH6 = flag_vec[5];

endmodule : lower_limit_compare_bank

/* File: lower_limit_chk.sv */
// Port checker for the lower-limit compare bank
`timescale 1ns/1ns
module lower_limit_chk
    import lower_limit_pkg::*;
(
    input wire logic              MCLK,
    input wire logic              SYS_RST,
    input wire logic              SPI_CS_N,
    input wire logic              SPI_DOUT,
    input wire logic [DATA_W-1:0] RESULT_CH1,
    input wire logic [DATA_W-1:0] RESULT_CH2,
    input wire logic [DATA_W-1:0] RESULT_CH3,
    input wire logic [DATA_W-1:0] RESULT_CH4,
    input wire logic [DATA_W-1:0] RESULT_CH5,
    input wire logic [DATA_W-1:0] RESULT_CH6,
    input wire logic              POLARITY_SELECT,
    input wire logic              OUTPUT_FORMAT,
    input wire logic              BELOW_LIMIT_FLAG_CH1,
    input wire logic              BELOW_LIMIT_FLAG_CH2,
    input wire logic              BELOW_LIMIT_FLAG_CH3,
    input wire logic              BELOW_LIMIT_FLAG_CH4,
    input wire logic              BELOW_LIMIT_FLAG_CH5,
    input wire logic              BELOW_LIMIT_FLAG_CH6
);
    logic [145:0] ins;
    logic [5:0]   flg;
    logic [5:0]   top;
    logic [5:0]   edg;
    logic         sgn;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    // Gathered inputs, flags and results that can never sit below a limit
    assign ins = {POLARITY_SELECT, OUTPUT_FORMAT, RESULT_CH6, RESULT_CH5, RESULT_CH4,
                  RESULT_CH3, RESULT_CH2, RESULT_CH1};
    assign flg = {BELOW_LIMIT_FLAG_CH6, BELOW_LIMIT_FLAG_CH5, BELOW_LIMIT_FLAG_CH4,
                  BELOW_LIMIT_FLAG_CH3, BELOW_LIMIT_FLAG_CH2, BELOW_LIMIT_FLAG_CH1};
    assign sgn = !POLARITY_SELECT && !OUTPUT_FORMAT;
    for (genvar i = 0; i < 6; i++) begin : g_ch
        assign top[i] = ins[24*i +: 24] == 24'h7fffff;
        assign edg[i] = ins[24*i +: 24] == 24'hffffff;
    end
    a_flag_reset_clear: assert property (disable iff (1'b0) SYS_RST |=> flg == 6'h00 && !SPI_DOUT)
        else $error("flags or data out not clear after reset");
    a_dout_idle_low: assert property (SPI_CS_N [*8] |-> !SPI_DOUT)
        else $error("data out high outside a frame");
    a_signed_top_clear: assert property ((sgn && top != 6'h00) |=> (flg & $past(top)) == 6'h00)
        else $error("signed full-scale result flagged below limit");
    a_unsigned_edge_clear: assert property ((!sgn && edg != 6'h00) |=> (flg & $past(edg)) == 6'h00)
        else $error("unsigned full-scale result flagged below limit");
    a_flag_hold_steady: assert property (SPI_CS_N [*8] ##0 $stable(ins) |=> $stable(flg))
        else $error("flag moved with results, coding and limits unchanged");
endmodule : lower_limit_chk

bind lower_limit_compare_bank lower_limit_chk lower_limit_chk_i (
    .MCLK, .SYS_RST, .SPI_CS_N, .SPI_DOUT, .RESULT_CH1, .RESULT_CH2, .RESULT_CH3, .RESULT_CH4,
    .RESULT_CH5, .RESULT_CH6, .POLARITY_SELECT, .OUTPUT_FORMAT, .BELOW_LIMIT_FLAG_CH1,
    .BELOW_LIMIT_FLAG_CH2, .BELOW_LIMIT_FLAG_CH3, .BELOW_LIMIT_FLAG_CH4, .BELOW_LIMIT_FLAG_CH5,
    .BELOW_LIMIT_FLAG_CH6
);

/* File: lower_limit_compare_bank_bench.sv */
// Self-checking bench for the lower-limit compare bank
`timescale 1ns/1ns
module lower_limit_compare_bank_bench;
    import lower_limit_pkg::*;
    logic              mclk, sys_rst, cs_n, sclk, din, pol, fmt;
    wire logic         dout;
    wire logic [5:0]   flg;
    logic [DATA_W-1:0] res [6];
    logic [DATA_W-1:0] v [6];
    logic [DATA_W-1:0] rd;
    int                err_count, n_compared;

    lower_limit_compare_bank lower_limit_compare_bank_i (
        .MCLK(mclk), .SYS_RST(sys_rst), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_DIN(din),
        .SPI_DOUT(dout), .RESULT_CH1(res[0]), .RESULT_CH2(res[1]), .RESULT_CH3(res[2]),
        .RESULT_CH4(res[3]), .RESULT_CH5(res[4]), .RESULT_CH6(res[5]),
        .POLARITY_SELECT(pol), .OUTPUT_FORMAT(fmt), .BELOW_LIMIT_FLAG_CH1(flg[0]),
        .BELOW_LIMIT_FLAG_CH2(flg[1]), .BELOW_LIMIT_FLAG_CH3(flg[2]),
        .BELOW_LIMIT_FLAG_CH4(flg[3]), .BELOW_LIMIT_FLAG_CH5(flg[4]), .BELOW_LIMIT_FLAG_CH6(flg[5])
    );

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : tick

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Mode 0 frame of n bits, MSB first; data out sampled before each rise
    task automatic xfer(input logic [31:0] frm, input int n);
        cs_n = 1'b0;
        for (int b = 0; b < n; b++) begin
            din = frm[31-b];
            tick(6);
            rd = {rd[22:0], dout};
            sclk = 1'b1;
            tick(6);
            sclk = 1'b0;
        end
        tick(6);
        cs_n = 1'b1;
        din = 1'b0;
        tick(8);
    endtask : xfer

    task automatic wr(input logic [6:0] a, input logic [23:0] d);
        xfer({1'b0, a, d}, 32);
    endtask : wr

    task automatic rdchk(input logic [6:0] a, input logic [23:0] e);
        xfer({1'b1, a, 24'h000000}, 32);
        check(rd, e, "read back");
    endtask : rdchk

    // Expected flag: signed order only for bipolar two's complement
    function automatic logic below(input logic [23:0] r, input logic [23:0] l, input logic p, input logic f);
        return (!p && !f) ? ($signed(r) < $signed(l)) : (r < l);
    endfunction : below

    task automatic tally_and_finish;
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Hang guard
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {sys_rst, cs_n, sclk, din, pol, fmt} = 6'h32;
        res = '{default: 24'h000000};
        rd = 24'h000000;
        err_count = 0;
        n_compared = 0;
        tick(2);
        sys_rst = 1'b0;
        tick(4);
        check({18'h00000, flg}, 24'h000000, "flags after reset");
        for (int i = 0; i < 6; i++) begin
            rdchk(LOWER_LIMIT_CH1_ADDR + 7'(i), LIMIT_RESET);
        end
        for (int i = 0; i < 6; i++) begin
            v[i] = 24'h5a0000 ^ (24'h010203 * 24'(i + 1));
            wr(LOWER_LIMIT_CH1_ADDR + 7'(i), v[i]);
        end
        wr(7'h20, 24'hffffff);
        wr(7'h27, 24'hffffff);
        xfer({1'b0, LOWER_LIMIT_CH1_ADDR, 24'h000000}, 16);
        for (int i = 0; i < 6; i++) begin
            rdchk(LOWER_LIMIT_CH1_ADDR + 7'(i), v[i]);
        end
        rdchk(7'h27, READ_UNMAPPED);
        // Limits kept for every coding, so expectations follow the coding in force
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                pol = m[0];
                fmt = m[1];
                for (int i = 0; i < 6; i++) begin
                    res[i] = ((k == 3) ? 24'hffffff : (k == 2) ? 24'h7fffff :
                              ((k == 1) ? v[i] ^ 24'h800000 : v[i])) - 24'(i % 2);
                end
                tick(12);
                for (int i = 0; i < 6; i++) begin
                    check({23'h000000, flg[i]}, {23'h000000, below(res[i], v[i], pol, fmt)}, "flag");
                end
            end
        end
        // Host moves to signed coding and rewrites the channel 1 limit to match
        pol = 1'b0;
        fmt = 1'b0;
        res[0] = 24'h000000;
        wr(LOWER_LIMIT_CH1_ADDR, 24'hffffff);
        tick(2);
        check({23'h000000, flg[0]}, {23'h000000, below(res[0], 24'hffffff, pol, fmt)}, "rewritten limit");
        tally_and_finish();
    end
endmodule : lower_limit_compare_bank_bench
